// *** dv/cwu_far_side.sv ***
// Far-side model of the waveform unit: input waveform source and active-low fault lines.
`default_nettype none
module cwu_far_side (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic       lvl_i,
  input  wire logic [5:0] fault_i,
  output var  logic       sig_o,
  output var  logic [5:0] shdn_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] ph;
  initial begin
    ph = 3'h0;
    sig_o = 1'b0;
    shdn_n_o = 6'h3F;
  end
  // The waveform toggles every eight cycles while running; stopped, it rests at a level.
  always @(posedge clk_i) begin
    ph <= ph + 3'h1;
    if (!run_i) begin
      sig_o <= lvl_i;
    end else if (ph == 3'h7) begin
      sig_o <= ~sig_o;
    end
  end
  // Faults are levels held low for as long as they last; idle lines sit high.
  always @(posedge clk_i) begin
    shdn_n_o <= ~fault_i;
  end
endmodule : cwu_far_side
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking testbench of the waveform unit over its AXI4-Lite register port.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, awv, wv, bready, arv, rready, run, lvl;
  logic [7:0] awa, ara, v, p;
  logic [31:0] wd;
  logic [3:0] stb;
  logic [5:0] flt;
  wire logic awr, wr, bv, arr, rv, fosc, sig;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rd;
  wire logic [3:0] dout, doe;
  wire logic [5:0] shn;
  int errors, tests_run, seed;

  cwu_top cwu_top_inst (.MCLK_I(clk), .SRST_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(stb), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready), .SIG_I(sig),
    .SHDN_N_I(shn), .DRIVE_OUT_O(dout), .DRIVE_OE_O(doe), .FAST_OSC_REQ_O(fosc));
  cwu_far_side cwu_far_side_inst (.clk_i(clk), .run_i(run), .lvl_i(lvl), .fault_i(flt),
    .sig_o(sig), .shdn_n_o(shn));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, e, input string s);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // Address and data are offered together; each is dropped at the edge that takes it.
  task automatic axw(input logic [7:0] a, d, input logic [1:0] er);
    int n;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (aw && awr) begin
        aw = 1'b0;
        awv <= 1'b0;
      end
      if (w && wr) begin
        w = 1'b0;
        wv <= 1'b0;
      end
    end while ((aw || w) && n < 100);
    while (!bv && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(bresp, er, "write response");
    bready <= 1'b0;
  endtask : axw

  // Read data is taken at the edge where rvalid is seen high; m masks undefined bits.
  task automatic axr(input logic [7:0] a, e, m, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 200);
    chk(rd & {24'hFF_FFFF, m}, {24'h00_0000, e & m}, "read data");
    chk(rresp, er, "read response");
    rready <= 1'b0;
  endtask : axr

  // Expected {enables, levels} under shutdown; tri-stated outputs have their level masked.
  function automatic logic [7:0] ovr(input logic [1:0] bd, ac, input logic [3:0] pol);
    logic [1:0] c;
    logic [3:0] o, e;
    for (int i = 0; i < 4; i++) begin
      c = i[0] ? bd : ac;
      e[i] = (c != 2'h1);
      o[i] = (c == 2'h0) ? pol[i] : c[0];
    end
    return {e, o & e};
  endfunction : ovr

  task automatic give_verdict;
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // The whole sequence needs about 800 cycles; the limit leaves a wide margin.
  initial begin
    #80000;
    errors++;
    give_verdict();
  end

  initial begin
    seed = 39659;
    errors = 0;
    tests_run = 0;
    {rst, awv, wv, bready, arv, rready, run, lvl} = 8'h80;
    {awa, ara, wd, flt, v, p} = '0;
    stb = 4'hF;
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    chk({doe, fosc}, 5'h00, "reset outputs");
    axr(8'h00, 8'h00, 8'hFF, 2'h0);
    axr(8'h10, 8'h14, 8'hFF, 2'h0);
    axr(8'h04, 8'h00, 8'hDF, 2'h0);
    axr(8'h1C, 8'h00, 8'hFF, 2'h2);
    axw(8'h01, 8'h55, 2'h2);
    // Every mode code, reserved ones included, is stored; bits 5 to 3 stay zero.
    for (int m = 0; m < 8; m++) begin
      axw(8'h00, 8'h38 | m[7:0], 2'h0);
      axr(8'h00, m[7:0], 8'hFF, 2'h0);
    end
    axw(8'h00, 8'hC0, 2'h0);
    axr(8'h00, 8'h80, 8'hFF, 2'h0);
    axw(8'h00, 8'h00, 2'h0);
    repeat (4) begin
      v = 8'($random(seed));
      axw(8'h08, v, 2'h0);
      axw(8'h0C, ~v, 2'h0);
      axr(8'h08, v & 8'h3F, 8'hFF, 2'h0);
      axr(8'h0C, ~v & 8'h3F, 8'hFF, 2'h0);
    end
    // A write with its low strobe off leaves the register alone.
    stb <= 4'h0;
    axw(8'h08, ~v, 2'h0);
    stb <= 4'hF;
    axr(8'h08, v & 8'h3F, 8'hFF, 2'h0);
    p = 8'($random(seed)) & 8'h0F;
    axw(8'h04, p | 8'hF0, 2'h0);
    // Every pair of override codes, forced by software while disabled, polarity random.
    for (int k = 0; k < 16; k++) begin
      axw(8'h10, {2'b10, k[3:0], 2'b11}, 2'h0);
      cyc(6);
      chk({doe, dout & doe}, ovr(k[3:2], k[1:0], p[3:0]), "override");
      axr(8'h10, {2'b10, k[3:0], 2'b00}, 8'hFF, 2'h0);
    end
    axw(8'h10, 8'hBF, 2'h0);
    axw(8'h14, 8'h01, 2'h0);
    axw(8'h00, 8'h80, 2'h0);
    cyc(6);
    chk({doe, dout}, 8'hFF, "start in shutdown");
    axw(8'h10, 8'h3C, 2'h0);
    axr(8'h10, 8'h3C, 8'hFF, 2'h0);
    cyc(8);
    chk({doe, dout}, 8'hFF, "override before rise");
    lvl <= 1'b1;
    cyc(8);
    chk({doe, dout}, {4'hF, ~p[3:0]}, "steer high");
    axr(8'h04, p | 8'h20, 8'hFF, 2'h0);
    lvl <= 1'b0;
    cyc(8);
    chk({doe, dout}, {4'hF, p[3:0]}, "steer low");
    axr(8'h04, p, 8'hFF, 2'h0);
    // Half bridge with a settled input: A and C follow it, B and D its inverse.
    axw(8'h00, 8'h84, 2'h0);
    lvl <= 1'b1;
    cyc(80);
    chk({doe, dout}, {4'hF, 4'h5 ^ p[3:0]}, "half bridge high");
    lvl <= 1'b0;
    cyc(80);
    chk({doe, dout}, {4'hF, 4'hA ^ p[3:0]}, "half bridge low");
    // A load request waits for an input edge, then clears itself.
    axw(8'h00, 8'hC0, 2'h0);
    axr(8'h00, 8'hC0, 8'hFF, 2'h0);
    lvl <= 1'b1;
    cyc(8);
    axr(8'h00, 8'h80, 8'hFF, 2'h0);
    flt <= 6'h01;
    cyc(8);
    chk({doe, dout}, 8'hFF, "fault override");
    axr(8'h10, 8'hBC, 8'hFF, 2'h0);
    axw(8'h10, 8'h3C, 2'h0);
    axr(8'h10, 8'hBC, 8'hFF, 2'h0);
    axw(8'h10, 8'h7C, 2'h0);
    axr(8'h10, 8'hFC, 8'hFF, 2'h0);
    flt <= 6'h00;
    cyc(8);
    axr(8'h10, 8'h7C, 8'hFF, 2'h0);
    flt <= 6'h02;
    cyc(8);
    axr(8'h10, 8'h7C, 8'hFF, 2'h0);
    flt <= 6'h00;
    run <= 1'b1;
    axw(8'h14, 8'h81, 2'h0);
    cyc(4);
    chk(fosc, 1'b1, "fast clock request");
    axw(8'h00, 8'h00, 2'h0);
    cyc(4);
    chk(fosc, 1'b0, "fast clock release");
    // A reserved mode, enabled on the system clock, holds every pin at its inactive level.
    axw(8'h14, 8'h01, 2'h0);
    axw(8'h00, 8'h86, 2'h0);
    cyc(40);
    chk({doe, dout}, {4'hF, p[3:0]}, "reserved mode idle");
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// *** verilog/cwu_params.svh ***
// Register offsets, field positions, reset values and timing figures of the waveform unit.
`ifndef CWU_PARAMS_SVH
`define CWU_PARAMS_SVH

// Byte offsets of the registers on the AXI4-Lite bus.
`define CWU_OFF_CTRL       8'h00
`define CWU_OFF_POL        8'h04
`define CWU_OFF_DBR        8'h08
`define CWU_OFF_DBF        8'h0C
`define CWU_OFF_SHD        8'h10
`define CWU_OFF_AUX        8'h14

// Register index codes produced by the address decoder.
`define CWU_IDX_CTRL       3'h0
`define CWU_IDX_POL        3'h1
`define CWU_IDX_DBR        3'h2
`define CWU_IDX_DBF        3'h3
`define CWU_IDX_SHD        3'h4
`define CWU_IDX_AUX        3'h5
`define CWU_IDX_NONE       3'h7

// Field positions.
`define CWU_CTRL_EN        7
`define CWU_CTRL_LD        6
`define CWU_POL_IN         5
`define CWU_SHD_FLAG       7
`define CWU_SHD_REN        6
`define CWU_AUX_CS         7

// Reset values of the override fields (both select tri-state).
`define CWU_LSBD_RST       2'h1
`define CWU_LSAC_RST       2'h1

// Override level codes.
`define CWU_LVL_HIGH       2'h3
`define CWU_LVL_LOW        2'h2
`define CWU_LVL_TRI        2'h1

// Clock rates in MHz; the fast oscillator tick is a fractional enable.
`define CWU_SYS_CLK_MHZ    9'h0FA
`define CWU_FAST_OSC_MHZ   9'h010

// Saturation value of the dead-band counter.
`define CWU_CNT_MAX        6'h3F

// AXI response codes.
`define CWU_RESP_OKAY      2'h0
`define CWU_RESP_SLVERR    2'h2

`endif

// *** verilog/cwu_pkg.sv ***
// Types shared by the waveform unit: mode codes and the packed state record.
`default_nettype none
`include "cwu_params.svh"

package cwu_pkg;

  // Operating modes selected by the control register.
  typedef enum logic [2:0] {
    CWU_STEER      = 3'h0,
    CWU_STEER_SYNC = 3'h1,
    CWU_FB_FWD     = 3'h2,
    CWU_FB_REV     = 3'h3,
    CWU_HALF       = 3'h4,
    CWU_PUSH_PULL  = 3'h5
  } cwu_mode_t;

  // Every flip-flop of the unit.
  typedef struct packed {
    logic       en;
    logic       ld;
    logic [2:0] mode;
    logic [3:0] pol;
    logic [5:0] dbr;
    logic [5:0] dbf;
    logic [5:0] rise_act;
    logic [5:0] fall_act;
    logic       shut;
    logic       ren;
    logic [1:0] lsbd;
    logic [1:0] lsac;
    logic [5:0] src_en;
    logic       cs;
    logic       in_s1;
    logic       in_s2;
    logic       in_q;
    logic [5:0] sd_s1;
    logic [5:0] sd_s2;
    logic [8:0] acc;
    logic       hold;
    logic [5:0] cnt;
    logic       pp_t;
    logic       dir_q;
    logic       db_run;
    logic [3:0] out;
    logic [3:0] oe;
    logic       osc_req;
    logic       aw_got;
    logic [7:0] awaddr;
    logic       w_got;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } cwu_state_t;

endpackage : cwu_pkg

`default_nettype wire

// *** verilog/cwu_top.sv ***
// Complementary waveform unit: AXI4-Lite registers, mode logic, dead band and shutdown.
//
// Contract
// - Generator keeps running from its own clock while clock and input stay active.
// - Fast oscillator kept requested when enabled, selected and input active, even asleep.
// - Shutdown levels: one field for B and D, one for A and C; polarity used only by code 00.
// - Level codes: 11 high, 10 low, 01 tri-state, 00 inactive level with polarity.
// - Without auto-resume, software clear works only when no selected source is active.
// - With auto-resume, hardware clears the flag once all selected sources go inactive.
// - Override levels stay until the first input rising event after the flag clears.
// - Load request moves dead-band values at next input edge, then clears itself.
// - Load request is accepted only while the module is already enabled.
// - Mode codes: steer, sync steer, forward, reverse, half-bridge, push-pull; rest reserved.
// - Polarity bits 3 to 0 invert outputs D, C, B, A; reset to zero.
// - Rising dead-band count is six bits, upper bits zero, kept over reset.
// - Falling dead-band count is six bits, upper bits zero, kept over reset.
// - Shutdown status bit 7 is set by hardware and reads one while shut down.
// - Writing one to the shutdown flag forces the override levels unless auto-restart is on and no source is active.
// - Shutdown bit 6 selects auto-restart; bits 1 and 0 read zero.
// - Dead band is counted in generator clock periods from zero to the value.
// - Shutdown sources act on level and hold the shutdown while active.
// - Clock select one picks the 16 MHz fast oscillator, zero the system clock.
`default_nettype none
`include "cwu_params.svh"

module cwu_top (
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output var  logic        S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output var  logic        S_AXI_WREADY_O,
  output var  logic [1:0]  S_AXI_BRESP_O,
  output var  logic        S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output var  logic        S_AXI_ARREADY_O,
  output var  logic [31:0] S_AXI_RDATA_O,
  output var  logic [1:0]  S_AXI_RRESP_O,
  output var  logic        S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        SIG_I,
  input  wire logic [5:0]  SHDN_N_I,
  output var  logic [3:0]  DRIVE_OUT_O,
  output var  logic [3:0]  DRIVE_OE_O,
  output var  logic        FAST_OSC_REQ_O
);
  import cwu_pkg::*;

  cwu_pkg::cwu_state_t st;
  cwu_pkg::cwu_state_t n;
  logic [8:0] acc_sum;
  logic       acc_wrap;
  logic       tick;
  logic       rise_evt;
  logic       edge_evt;
  logic       sd_act;
  logic       wr_fire;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic [7:0] wd;

  // Maps a byte address onto a register index; misaligned or unknown gives none.
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    logic [2:0] idx;
    idx = `CWU_IDX_NONE;
    case (a)
      `CWU_OFF_CTRL: idx = `CWU_IDX_CTRL;
      `CWU_OFF_POL:  idx = `CWU_IDX_POL;
      `CWU_OFF_DBR:  idx = `CWU_IDX_DBR;
      `CWU_OFF_DBF:  idx = `CWU_IDX_DBF;
      `CWU_OFF_SHD:  idx = `CWU_IDX_SHD;
      `CWU_OFF_AUX:  idx = `CWU_IDX_AUX;
      default:       idx = `CWU_IDX_NONE;
    endcase
    return idx;
  endfunction : reg_index

  // Generator tick: every system cycle, or a fractional 16-in-250 enable for the fast clock.
  // The fractional tick jitters by one system cycle; dead-band uncertainty is one tick anyway.
  assign acc_sum  = st.acc + `CWU_FAST_OSC_MHZ;
  assign acc_wrap = (acc_sum >= `CWU_SYS_CLK_MHZ);
  assign tick     = st.cs ? acc_wrap : 1'b1;
  assign rise_evt = tick & st.in_s2 & ~st.in_q;
  assign edge_evt = tick & (st.in_s2 ^ st.in_q);
  // Sources are active low and act on level only.
  assign sd_act   = |(~st.sd_s2 & st.src_en);
  assign wr_fire  = st.aw_got & st.w_got & ~st.bvalid;
  assign wr_idx   = reg_index(st.awaddr);
  assign rd_idx   = reg_index(S_AXI_ARADDR_I);
  assign wd       = st.wdata;

  // Next-state logic for the whole unit.
  always_comb begin
    logic       mod_ok;
    logic [3:0] raw;
    logic [1:0] lvl;
    n      = st;
    mod_ok = 1'b0;
    raw    = 4'h0;
    lvl    = 2'h0;

    // Two-stage synchronisers for the pins.
    n.in_s1 = SIG_I;
    n.in_s2 = st.in_s1;
    n.sd_s1 = SHDN_N_I;
    n.sd_s2 = st.sd_s1;

    // Fractional divider runs only while the fast clock is selected.
    if (st.cs) begin
      n.acc = acc_wrap ? acc_sum - `CWU_SYS_CLK_MHZ : acc_sum;
    end else begin
      n.acc = 9'h000;
    end

    // Input sampling and dead-band counting on generator ticks.
    if (tick) begin
      n.in_q = st.in_s2;
      if (edge_evt) begin
        n.cnt = 6'h00;
      end else if (st.cnt != `CWU_CNT_MAX) begin
        n.cnt = st.cnt + 6'h01;
      end
    end
    if (rise_evt) begin
      n.pp_t   = ~st.pp_t;
      n.dir_q  = st.mode[0];
      n.db_run = (st.mode[0] != st.dir_q);
    end

    // Double-buffered dead band: live copy while disabled, else on request at an edge.
    if (!st.en) begin
      n.rise_act = st.dbr;
      n.fall_act = st.dbf;
    end else if (st.ld && edge_evt) begin
      n.rise_act = st.dbr;
      n.fall_act = st.dbf;
      n.ld       = 1'b0;
    end

    // Write address and data are taken independently; the write runs when both are held.
    if (S_AXI_AWVALID_I && st.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && st.wready) begin
      n.w_got  = 1'b1;
      n.wdata  = S_AXI_WDATA_I[7:0];
      n.wstrb0 = S_AXI_WSTRB_I[0];
    end
    if (st.bvalid && S_AXI_BREADY_I) begin
      n.bvalid = 1'b0;
    end
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = (wr_idx == `CWU_IDX_NONE) ? `CWU_RESP_SLVERR : `CWU_RESP_OKAY;
      if (st.wstrb0) begin
        case (wr_idx)
          `CWU_IDX_CTRL: begin
            n.en   = wd[`CWU_CTRL_EN];
            n.ld   = wd[`CWU_CTRL_LD] & st.en;
            n.mode = wd[2:0];
          end
          `CWU_IDX_POL: n.pol = wd[3:0];
          `CWU_IDX_DBR: n.dbr = wd[5:0];
          `CWU_IDX_DBF: n.dbf = wd[5:0];
          `CWU_IDX_SHD: begin
            n.ren  = wd[`CWU_SHD_REN];
            n.lsbd = wd[5:4];
            n.lsac = wd[3:2];
            if (wd[`CWU_SHD_FLAG]) begin
              n.shut = 1'b1;
            end else if (!sd_act) begin
              n.shut = 1'b0;
            end
          end
          `CWU_IDX_AUX: begin
            n.cs     = wd[`CWU_AUX_CS];
            n.src_en = wd[5:0];
          end
          default: n.en = st.en;
        endcase
      end
    end

    // Auto-restart clears the flag; an active source always sets it and wins over any clear.
    if (st.ren && !sd_act) begin
      n.shut = 1'b0;
    end
    if (sd_act) begin
      n.shut = 1'b1;
    end
    // Overrides persist until a rising event seen after the flag was already clear.
    n.hold = n.shut | (st.hold & ~(rise_evt & ~st.shut));

    // Read channel: one outstanding read, answer registered one cycle after acceptance.
    if (st.rvalid && S_AXI_RREADY_I) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && st.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = (rd_idx == `CWU_IDX_NONE) ? `CWU_RESP_SLVERR : `CWU_RESP_OKAY;
      case (rd_idx)
        `CWU_IDX_CTRL: n.rdata = {st.en, st.ld, 3'h0, st.mode};
        `CWU_IDX_POL:  n.rdata = {2'h0, st.in_s2, 1'h0, st.pol};
        `CWU_IDX_DBR:  n.rdata = {2'h0, st.dbr};
        `CWU_IDX_DBF:  n.rdata = {2'h0, st.dbf};
        `CWU_IDX_SHD:  n.rdata = {st.shut, st.ren, st.lsbd, st.lsac, 2'h0};
        `CWU_IDX_AUX:  n.rdata = {st.cs, 1'h0, st.src_en};
        default:       n.rdata = 8'h00;
      endcase
    end
    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready  = ~n.w_got & ~n.bvalid;
    n.arready = ~n.rvalid;

    // Raw waveform per mode; bit 0 is output A, bit 3 output D.
    mod_ok = ~n.db_run | (n.cnt >= (n.dir_q ? n.rise_act : n.fall_act));
    case (cwu_mode_t'(n.mode))
      CWU_STEER, CWU_STEER_SYNC: raw = {4{n.in_q}};
      CWU_FB_FWD, CWU_FB_REV: begin
        if (n.dir_q) begin
          raw = {1'b0, 1'b1, n.in_q & mod_ok, 1'b0};
        end else begin
          raw = {n.in_q & mod_ok, 1'b0, 1'b0, 1'b1};
        end
      end
      CWU_HALF: begin
        raw[0] = n.in_q & (n.cnt >= n.rise_act);
        raw[1] = ~n.in_q & (n.cnt >= n.fall_act);
        raw[3:2] = raw[1:0];
      end
      CWU_PUSH_PULL: raw = {n.in_q & n.pp_t, n.in_q & ~n.pp_t, n.in_q & n.pp_t, n.in_q & ~n.pp_t};
      default: raw = 4'h0;
    endcase

    // Output stage: polarity on the waveform, overrides take precedence while held.
    n.out = n.en ? (raw ^ n.pol) : n.pol;
    n.oe  = n.en ? 4'hF : 4'h0;
    if (n.hold) begin
      for (int i = 0; i < 4; i++) begin
        lvl = i[0] ? n.lsbd : n.lsac;
        case (lvl)
          `CWU_LVL_HIGH: begin n.out[i] = 1'b1; n.oe[i] = 1'b1; end
          `CWU_LVL_LOW:  begin n.out[i] = 1'b0; n.oe[i] = 1'b1; end
          `CWU_LVL_TRI:  begin n.out[i] = 1'b0; n.oe[i] = 1'b0; end
          default:       begin n.out[i] = n.pol[i]; n.oe[i] = 1'b1; end
        endcase
      end
    end
    // The fast oscillator must not be released while it clocks an enabled generator.
    n.osc_req = n.en & n.cs;

    // Synchronous reset; dead-band counts survive it.
    if (SRST_I) begin
      n          = '0;
      n.dbr      = st.dbr;
      n.dbf      = st.dbf;
      n.rise_act = st.rise_act;
      n.fall_act = st.fall_act;
      n.lsbd     = `CWU_LSBD_RST;
      n.lsac     = `CWU_LSAC_RST;
      n.sd_s1    = 6'h3F;
      n.sd_s2    = 6'h3F;
      n.awready  = 1'b1;
      n.wready   = 1'b1;
      n.arready  = 1'b1;
    end
  end

  // The single state register.
  always_ff @(posedge MCLK_I) begin
    st <= n;
  end

  // Every output comes straight from the state register.
  assign S_AXI_AWREADY_O = st.awready;
  assign S_AXI_WREADY_O  = st.wready;
  assign S_AXI_BVALID_O  = st.bvalid;
  assign S_AXI_BRESP_O   = st.bresp;
  assign S_AXI_ARREADY_O = st.arready;
  assign S_AXI_RVALID_O  = st.rvalid;
  assign S_AXI_RRESP_O   = st.rresp;
  assign S_AXI_RDATA_O   = {24'h00_0000, st.rdata};
  assign DRIVE_OUT_O     = st.out;
  assign DRIVE_OE_O      = st.oe;
  assign FAST_OSC_REQ_O  = st.osc_req;

  // Checks tied to the logic above.
  reserved_mode_idle_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.en && st.mode[2:1] == 2'b11 && !st.hold)
      |-> (DRIVE_OUT_O == st.pol && DRIVE_OE_O == 4'hF))
    else $error("reserved mode drove an active level");
  override_ac_high_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.hold && st.lsac == 2'h3)
      |-> (DRIVE_OUT_O[0] && DRIVE_OUT_O[2] && DRIVE_OE_O[0] && DRIVE_OE_O[2]))
    else $error("A/C override high not driven");

  // A low override must still drive the pin, otherwise a bridge leg could float.
  override_ac_low_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.hold && st.lsac == 2'h2)
      |-> (!DRIVE_OUT_O[0] && !DRIVE_OUT_O[2] && DRIVE_OE_O[0] && DRIVE_OE_O[2]))
    else $error("A/C override low not driven");

  // The inactive code follows the polarity bits of the B and D pins.
  override_bd_idle_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.hold && st.lsbd == 2'h0)
      |-> (DRIVE_OUT_O[1] == st.pol[1] && DRIVE_OUT_O[3] == st.pol[3] && DRIVE_OE_O[1]))
    else $error("B/D inactive override wrong");

  // Software writes to the flag: a one forces shutdown while auto-restart is off.
  soft_force_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (wr_fire && st.wstrb0 && wr_idx == `CWU_IDX_SHD && st.wdata[`CWU_SHD_FLAG] && !st.ren)
      |=> st.shut)
    else $error("software shutdown write did not set the flag");

  // A zero written while every selected source is quiet must clear the flag.
  soft_clear_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (wr_fire && st.wstrb0 && wr_idx == `CWU_IDX_SHD && !st.wdata[`CWU_SHD_FLAG] && !sd_act)
      |=> !st.shut)
    else $error("software clear ignored with sources quiet");

  // In half-bridge mode output A stays inactive until the rising count is reached.
  half_rise_delay_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.en && st.mode == 3'h4 && !st.hold && st.cnt < st.rise_act)
      |-> (DRIVE_OUT_O[0] == st.pol[0]))
    else $error("half-bridge A rose inside the dead band");

  // A pending load request waits for an input edge.
  load_pending_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.en && st.ld && !edge_evt && !wr_fire) |=> st.ld)
    else $error("load request dropped without an input edge");

  // A disabled unit with no override levels held leaves every pin undriven.
  disabled_undriven_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (!st.en && !st.hold) |-> (DRIVE_OE_O == 4'h0))
    else $error("disabled unit drove a pin");
  override_bd_tri_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.hold && st.lsbd == 2'h1) |-> (!DRIVE_OE_O[1] && !DRIVE_OE_O[3]))
    else $error("B/D override not tri-stated");
  source_holds_flag_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    sd_act |=> st.shut)
    else $error("shutdown flag clear while a source was active");
  auto_restart_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.shut && st.ren && !sd_act && !wr_fire) |=> !st.shut)
    else $error("auto-restart did not clear the flag");
  hold_until_rise_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.hold && !st.shut && !rise_evt) |=> st.hold)
    else $error("override released without a rising event");
  load_transfer_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.en && st.ld && edge_evt) |=> (!st.ld && st.rise_act == $past(st.dbr)))
    else $error("buffer load did not transfer and clear");
  load_needs_en_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    $rose(st.ld) |-> $past(st.en))
    else $error("load request accepted while disabled");
  osc_request_a: assert property (@(posedge MCLK_I) disable iff (SRST_I)
    (st.en && st.cs) |-> FAST_OSC_REQ_O)
    else $error("fast oscillator request dropped");

endmodule : cwu_top

`default_nettype wire
